//--- soft_power_switch_controller.v
// Functional notes
// [RULE1] Press in standby powers up into self-test
// [RULE2] Press in self-test or non-ACPI powers off; in ST_SUSP a press goes to ST_RUN instead, with or without ACPI
// [RULE3] Hold over four seconds forces power off
// [RULE4] Cleared settings at mains return: wait press
// [RULE5] Valid settings, wake option on: power up
// [RULE6] Wake option off: wait, drop resume events
// [RULE7] Sleep indicator low in power-managed states
// [RULE8] Fan stopped during suspend, restored after
// [RULE9] Variable fan speed follows processor temperature; only with ACPI set as well, otherwise the fan runs at full
// [RULE10] Intrusion latched on backup power, kept
// [RULE11] Debounced switch; short press released before timeout
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_sw_regs.vh"
module soft_power_switch_controller #(
  parameter integer HOLD_CYCLES = `CLK_HZ / 1000 * `HOLD_MS,
  parameter integer DEB_CYCLES  = `CLK_HZ / 1000000 * `DEBOUNCE_US
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        standby_switch,
  input  wire        mains_ok,
  input  wire        intrusion_latched_in,
  input  wire [7:0]  cpu_temp,
  output reg         supply_on,
  output reg         post_release,
  output reg         sleep_indicator_n,
  output reg  [7:0]  fan_drive
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [3:0] ST_OFF  = 4'h1;
  localparam [3:0] ST_POST = 4'h2;
  localparam [3:0] ST_RUN  = 4'h4;
  localparam [3:0] ST_SUSP = 4'h8;

  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [31:0] ctrl;
  reg  [31:0] hold_cnt;
  reg         sw_prev;
  reg         forced;
  reg         press_seen;
  reg         mains_prev;
  reg         intrude;
  wire        sw_clean;
  wire [7:0]  curve_speed;
  wire        hold_expired;
  wire        short_press;
  wire        mains_rise;
  wire        apb_wr;
  wire        apb_rd;

  switch_debounce #(.COUNT(DEB_CYCLES)) u_deb (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (standby_switch),
    .clean   (sw_clean)
  );

  fan_curve u_fan (
    .pclk    (pclk),
    .presetn (presetn),
    .temp    (cpu_temp),
    .speed   (curve_speed)
  );

  // ----------------------------------------
  // Switch timing
  // ----------------------------------------
  assign hold_expired = sw_clean && (hold_cnt >= HOLD_CYCLES - 1);
  // Release after a forced-off hold is not a press, or it would power back up
  assign short_press  = sw_prev && !sw_clean && !forced; // [RULE11]
  assign mains_rise   = mains_ok && !mains_prev;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_prev    <= 1'b0;
      hold_cnt   <= 32'h0000_0000;
      forced     <= 1'b0;
      mains_prev <= 1'b0;
    end
    else
    begin
      sw_prev    <= sw_clean;
      mains_prev <= mains_ok;
      if (!sw_clean)
      begin
        hold_cnt <= 32'h0000_0000;
        forced   <= 1'b0;
      end
      else if (hold_expired)
        forced <= 1'b1; // [RULE3]
      else
        hold_cnt <= hold_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      ST_OFF:
      begin
        if (mains_rise && ctrl[`CTRL_SETTINGS] && ctrl[`CTRL_WAKE])
          next_state = ST_POST; // [RULE5]
        else if (short_press && mains_ok)
          next_state = ST_POST; // [RULE1]
      end
      ST_POST:
      begin
        if (short_press)
          next_state = ST_OFF; // [RULE2]
        else if (ctrl[`CTRL_ACPI] || ctrl[`CTRL_SWOFF])
          next_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (short_press && !ctrl[`CTRL_ACPI])
          next_state = ST_OFF; // [RULE2]
        else if (ctrl[`CTRL_SUSPEND])
          next_state = ST_SUSP;
        else if (ctrl[`CTRL_SWOFF])
          next_state = ST_OFF;
      end
      ST_SUSP:
      begin
        if (short_press || !ctrl[`CTRL_SUSPEND])
          next_state = ST_RUN;
      end
      default:
        next_state = ST_OFF;
    endcase
    // Hardware override: no software bit can hold the supply on
    if (hold_expired && !forced)
      next_state = ST_OFF; // [RULE3]
    // Mains loss drops everything, resume included
    if (!mains_ok)
      next_state = ST_OFF; // [RULE6]
  end

  // Cleared settings or wake off simply leave ST_OFF waiting for a press
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_OFF; // [RULE4]
    else
      state <= next_state;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      supply_on         <= 1'b0;
      post_release      <= 1'b0;
      sleep_indicator_n <= 1'b1;
      fan_drive         <= 8'h00;
    end
    else
    begin
      supply_on    <= (next_state != ST_OFF); // [RULE1]
      post_release <= (next_state != ST_OFF); // [RULE1]
      sleep_indicator_n <= !((next_state == ST_SUSP) || (ctrl[`CTRL_SLEEP] && next_state == ST_RUN)); // [RULE7]
      if (next_state == ST_OFF || next_state == ST_SUSP)
        fan_drive <= 8'h00; // [RULE8]
      else if (ctrl[`CTRL_VARFAN] && ctrl[`CTRL_ACPI])
        fan_drive <= curve_speed; // [RULE9]
      else
        fan_drive <= `FAN_FULL;
    end
  end

  // ----------------------------------------
  // Events
  // ----------------------------------------
  assign apb_wr = psel && penable && pwrite && pready;
  assign apb_rd = psel && !penable && !pwrite;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      intrude    <= 1'b0;
      press_seen <= 1'b0;
    end
    else
    begin
      // Set beats write-one-to-clear in the same cycle
      if (intrusion_latched_in)
        intrude <= 1'b1; // [RULE10]
      else if (apb_wr && paddr == `REG_STATUS && pwdata[`STAT_INTRUDE])
        intrude <= 1'b0;
      if (short_press)
        press_seen <= 1'b1;
      else if (apb_wr && paddr == `REG_STATUS && pwdata[`STAT_PRESS])
        press_seen <= 1'b0;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl    <= `CTRL_RESET;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        if (paddr != `REG_CTRL && paddr != `REG_STATUS && paddr != `REG_TEMP && paddr != `REG_FAN)
          pslverr <= 1'b1;
      end
      if (apb_wr && paddr == `REG_CTRL)
        ctrl <= {25'h0000000, pwdata[6:0]};
      // Boot-done is used up in self-test, or it would power off at once
      else if (ctrl[`CTRL_SWOFF] && (state == ST_OFF || state == ST_POST))
        ctrl[`CTRL_SWOFF] <= 1'b0;
      if (!mains_ok)
        ctrl[`CTRL_SUSPEND] <= 1'b0; // [RULE6]
      if (apb_rd)
      begin
        if (paddr == `REG_CTRL)
          prdata <= ctrl;
        else if (paddr == `REG_STATUS)
          prdata <= {26'h0000000, press_seen, forced, intrude, state == ST_SUSP, state == ST_POST, state != ST_OFF};
        else if (paddr == `REG_TEMP)
          prdata <= {24'h000000, cpu_temp};
        else if (paddr == `REG_FAN)
          prdata <= {24'h000000, fan_drive};
        else
          prdata <= 32'h0000_0000;
      end
    end
  end
endmodule
`default_nettype wire

//--- pwr_sw_regs.vh
`ifndef PWR_SW_REGS_VH
`define PWR_SW_REGS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define REG_CTRL       12'h000
`define REG_STATUS     12'h004
`define REG_TEMP       12'h008
`define REG_FAN        12'h00c
// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_WAKE      0
`define CTRL_SETTINGS  1
`define CTRL_ACPI      2
`define CTRL_SUSPEND   3
`define CTRL_SLEEP     4
`define CTRL_VARFAN    5
`define CTRL_SWOFF     6
`define CTRL_RESET     32'h0000_0000
// ----------------------------------------
// Status fields
// ----------------------------------------
`define STAT_ON        0
`define STAT_POST      1
`define STAT_SUSP      2
`define STAT_INTRUDE   3
`define STAT_FORCED    4
`define STAT_PRESS     5
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ         125000000
`define HOLD_MS        4000
`define DEBOUNCE_US    10
`define FAN_FULL       8'hff
`endif

//--- switch_debounce.v
`timescale 1ns/1ps
`default_nettype none
module switch_debounce #(
  parameter integer COUNT = 1250
) (
  input  wire pclk,
  input  wire presetn,
  input  wire raw,
  output reg  clean
);
  reg [31:0] cnt;
  // ----------------------------------------
  // Stable-for-COUNT filter
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt   <= 32'h0000_0000;
      clean <= 1'b0;
    end
    else if (raw == clean)
      cnt <= 32'h0000_0000;
    else if (cnt >= COUNT - 1)
    begin
      cnt   <= 32'h0000_0000;
      clean <= raw; // [RULE11]
    end
    else
      cnt <= cnt + 32'h0000_0001;
  end
endmodule
`default_nettype wire

//--- fan_curve.v
`timescale 1ns/1ps
`default_nettype none
module fan_curve #(
  parameter [7:0] TEMP_LOW = 8'h28
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [7:0] temp,
  output reg  [7:0] speed
);
  // Speed rises linearly above the quiet threshold, clipped at full
  // Two spare bits, so the shift cannot wrap before the clip
  wire [9:0] scaled;
  assign scaled = (temp > TEMP_LOW) ? {2'b00, temp - TEMP_LOW} << 2 : 10'h000;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      speed <= 8'h00;
    else
      speed <= (scaled[9:8] != 2'b00) ? 8'hff : scaled[7:0]; // [RULE9]
  end
endmodule
`default_nettype wire

//--- pwr_sw_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pwr_sw_monitor #(
  parameter int HOLD_CYCLES = 200,
  parameter int DEB_CYCLES  = 4
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       standby_switch,
  input wire logic       mains_ok,
  input wire logic       supply_on,
  input wire logic       post_release,
  input wire logic       sleep_indicator_n,
  input wire logic [7:0] fan_drive
);
  // Four spare cycles beyond debounce and hold, for the registers
  localparam int HMAX = HOLD_CYCLES + DEB_CYCLES + 4;
  int hold_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Raw switch hold length
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      hold_cnt <= 0;
    else if (standby_switch)
      hold_cnt <= hold_cnt + 1;
    else
      hold_cnt <= 0;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_apb_ready;
    psel && !penable |=> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
  property p_apb_single;
    pready |=> !pready;
  endproperty
  a_apb_single: assert property (p_apb_single) else $error("ready longer than one cycle");
  property p_apb_err;
    pslverr |-> pready;
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("error without ready");
  property p_mains_off;
    !mains_ok |=> !supply_on;
  endproperty
  a_mains_off: assert property (p_mains_off) else $error("supply on without mains");
  property p_hold_off;
    hold_cnt >= HMAX |-> !supply_on;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("long hold kept supply on");
  property p_press_on;
    $fell(standby_switch) && !supply_on && mains_ok && hold_cnt > DEB_CYCLES + 2 && hold_cnt < HOLD_CYCLES
      |-> ##[1:12] supply_on && post_release;
  endproperty
  a_press_on: assert property (p_press_on) else $error("press in standby did not power up");
  property p_off_led;
    !supply_on [*3] |-> sleep_indicator_n;
  endproperty
  a_off_led: assert property (p_off_led) else $error("indicator low while off");
  property p_off_fan;
    !supply_on [*3] |-> fan_drive == 8'h00;
  endproperty
  a_off_fan: assert property (p_off_fan) else $error("fan driven while off");
endmodule
`default_nettype wire

//--- switch_supply_model.sv
`timescale 1ns/1ps
`default_nettype none
module switch_supply_model (
  input  wire logic pclk,
  output var  logic standby_switch,
  output var  logic mains_ok
);
  // ----------------------------------------
  // Front switch and mains feed
  // ----------------------------------------
  initial
  begin
    standby_switch = 1'b0;
    mains_ok = 1'b1;
  end
  task automatic press(input int n);
    @(posedge pclk) standby_switch <= 1'b1;
    repeat (n) @(posedge pclk);
    standby_switch <= 1'b0;
  endtask
  task automatic mains(input logic v);
    @(posedge pclk) mains_ok <= v;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwr_sw_regs.vh"
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        intrusion_latched_in;
  logic [7:0]  cpu_temp;
  logic [31:0] r;
  logic [7:0]  f;
  logic        e;
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;
  wire  [31:0] prdata;
  wire  [7:0]  fan_drive;
  wire         pready, pslverr, standby_switch, mains_ok, supply_on, post_release, sleep_indicator_n;
  // ----------------------------------------
  // Design, partner, clock
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    intrusion_latched_in = 1'b0;
    cpu_temp = 8'h10;
  end
  soft_power_switch_controller #(
    .HOLD_CYCLES (200),
    .DEB_CYCLES  (4)
  ) dut (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .standby_switch       (standby_switch),
    .mains_ok             (mains_ok),
    .intrusion_latched_in (intrusion_latched_in),
    .cpu_temp             (cpu_temp),
    .supply_on            (supply_on),
    .post_release         (post_release),
    .sleep_indicator_n    (sleep_indicator_n),
    .fan_drive            (fan_drive)
  );
  switch_supply_model sw (
    .pclk           (pclk),
    .standby_switch (standby_switch),
    .mains_ok       (mains_ok)
  );
  always #4 pclk = ~pclk;
  always @(posedge pclk)
    if (++cyc == 20000)
    begin
      fails++;
      conclude();
    end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x)
    begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  // Caller is just past an edge; held until pready sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
  endtask
  task automatic sup(input logic v);
    for (int n = 0; n < 400 && supply_on !== v; n++)
      @(posedge pclk);
    chk({31'h0, supply_on}, {31'h0, v});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`REG_CTRL, 32'hffff_ffff, `CTRL_RESET);
    rd(`REG_STATUS, 32'hffff_ffff, 32'h0);
    rd(12'h010, 32'hffff_ffff, 32'h0);
    chk({31'h0, e}, 32'h1);
    sw.mains(1'b0);
    sw.mains(1'b1);
    repeat (50) @(posedge pclk);
    sup(1'b0);
    sw.press(20);
    sup(1'b1);
    rd(`REG_STATUS, 32'h3, 32'h3);
    sw.press(20);
    sup(1'b0);
    sw.press(20);
    sup(1'b1);
    apb(1'b1, `REG_CTRL, 32'h1 << `CTRL_SWOFF);
    rd(`REG_STATUS, 32'h3, 32'h1);
    sw.press(20);
    sup(1'b0);
    sw.press(20);
    sup(1'b1);
    apb(1'b1, `REG_CTRL, (32'h1 << `CTRL_ACPI) | (32'h1 << `CTRL_SWOFF));
    apb(1'b1, `REG_STATUS, 32'h1 << `STAT_PRESS);
    sw.press(20);
    repeat (20) @(posedge pclk);
    sup(1'b1);
    rd(`REG_STATUS, 32'h1 << `STAT_PRESS, 32'h1 << `STAT_PRESS);
    sw.press(300);
    chk({31'h0, supply_on}, 32'h0);
    rd(`REG_STATUS, 32'h1 << `STAT_FORCED, 32'h1 << `STAT_FORCED);
    // Release after the forced hold must not power back up
    repeat (20) @(posedge pclk);
    chk({31'h0, supply_on}, 32'h0);
    sw.press(20);
    sup(1'b1);
    apb(1'b1, `REG_CTRL, 32'h1 << `CTRL_ACPI);
    rd(`REG_STATUS, 32'h3, 32'h1);
    apb(1'b1, `REG_CTRL, (32'h1 << `CTRL_ACPI) | (32'h1 << `CTRL_SUSPEND));
    repeat (4) @(posedge pclk);
    chk({23'h0, fan_drive, sleep_indicator_n}, 32'h0);
    apb(1'b1, `REG_CTRL, 32'h1 << `CTRL_ACPI);
    repeat (4) @(posedge pclk);
    chk({23'h0, fan_drive, sleep_indicator_n}, {23'h0, `FAN_FULL, 1'b1});
    apb(1'b1, `REG_CTRL, (32'h1 << `CTRL_ACPI) | (32'h1 << `CTRL_VARFAN));
    repeat (8) @(posedge pclk);
    f = fan_drive;
    cpu_temp <= 8'hc0;
    repeat (8) @(posedge pclk);
    chk({31'h0, fan_drive > f}, 32'h1);
    rd(`REG_TEMP, 32'hff, 32'hc0);
    rd(`REG_FAN, 32'hff, {24'h0, `FAN_FULL});
    apb(1'b1, `REG_CTRL, (32'h1 << `CTRL_ACPI) | (32'h1 << `CTRL_SLEEP));
    repeat (2) @(posedge pclk);
    chk({31'h0, sleep_indicator_n}, 32'h0);
    apb(1'b1, `REG_CTRL, (32'h1 << `CTRL_SETTINGS) | (32'h1 << `CTRL_SUSPEND));
    sw.mains(1'b0);
    sup(1'b0);
    sw.mains(1'b1);
    repeat (50) @(posedge pclk);
    sup(1'b0);
    rd(`REG_CTRL, 32'h7f, 32'h1 << `CTRL_SETTINGS);
    apb(1'b1, `REG_CTRL, (32'h1 << `CTRL_SETTINGS) | (32'h1 << `CTRL_WAKE));
    sw.mains(1'b0);
    sw.mains(1'b1);
    sup(1'b1);
    sw.mains(1'b0);
    @(posedge pclk) intrusion_latched_in <= 1'b1;
    @(posedge pclk) intrusion_latched_in <= 1'b0;
    rd(`REG_STATUS, 32'h1 << `STAT_INTRUDE, 32'h1 << `STAT_INTRUDE);
    apb(1'b1, `REG_STATUS, 32'h1 << `STAT_INTRUDE);
    rd(`REG_STATUS, 32'h1 << `STAT_INTRUDE, 32'h0);
    conclude();
  end
endmodule
bind soft_power_switch_controller pwr_sw_monitor #(
  .HOLD_CYCLES (HOLD_CYCLES),
  .DEB_CYCLES  (DEB_CYCLES)
) mon (
  .pclk              (pclk),
  .presetn           (presetn),
  .psel              (psel),
  .penable           (penable),
  .pready            (pready),
  .pslverr           (pslverr),
  .standby_switch    (standby_switch),
  .mains_ok          (mains_ok),
  .supply_on         (supply_on),
  .post_release      (post_release),
  .sleep_indicator_n (sleep_indicator_n),
  .fan_drive         (fan_drive)
);
`default_nettype wire
